//--- logic/ssw_cfg.svh
// Constants of the supply supervisor and watchdog: offsets, fields, timing.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
`ifndef SSW_CFG_SVH
`define SSW_CFG_SVH

// System clock and the internal timebase tick.
`define SSW_CLK_HZ        20000000
`define SSW_TICK_MS       1
`define SSW_TICK_CYCLES   ((`SSW_CLK_HZ / 1000) * `SSW_TICK_MS)
`define SSW_DIV_W         16

// Counter width for reset and watchdog timing, in ticks.
`define SSW_CNT_W         13

// Internal oscillator times, in milliseconds.
`define SSW_T_RST_MS      50
`define SSW_T_SHORT_MS    100
`define SSW_T_LONG_MS     1600
`define SSW_INT_RST       (`SSW_T_RST_MS / `SSW_TICK_MS)
`define SSW_INT_SHORT     (`SSW_T_SHORT_MS / `SSW_TICK_MS)
`define SSW_INT_LONG      (`SSW_T_LONG_MS / `SSW_TICK_MS)

// External timebase times, in timebase cycles.
`define SSW_EXT_RST       13'h0200
`define SSW_EXT_SHORT     13'h0400
`define SSW_EXT_LONG      13'h1000

// Register byte offsets.
`define SSW_ADDR_W        12
`define SSW_REG_STATUS    12'h000
`define SSW_REG_EVENTS    12'h004
`define SSW_REG_WDCNT     12'h008

// Status register fields.
`define SSW_ST_LINE       0
`define SSW_ST_WDO        1
`define SSW_ST_RST        2
`define SSW_ST_BACKUP     3
`define SSW_ST_AUX        4
`define SSW_ST_LONG       5
`define SSW_ST_EXT        6

// Event register fields, write one to clear.
`define SSW_EV_WDT        0
`define SSW_EV_LOW        1

`endif

//--- logic/ssw_pkg.sv
// Types shared by the supply supervisor and its timebase.
// Assumes ssw_cfg.svh is on the include path.
package ssw_pkg;
`include "ssw_cfg.svh"

    typedef enum logic [1:0] {
        SSW_LVL_MID  = 2'b00,
        SSW_LVL_LOW  = 2'b01,
        SSW_LVL_HIGH = 2'b10
    } ssw_lvl_t;

    typedef enum logic {
        SSW_SUP_RESET = 1'b0,
        SSW_SUP_RUN   = 1'b1
    } ssw_mode_t;

    typedef struct packed {
        logic                  sel_s1;
        logic                  sel_s2;
        logic                  in_s1;
        logic                  in_s2;
        logic                  in_s3;
        logic [`SSW_DIV_W-1:0] div;
        logic                  tick;
    } ssw_tb_st_t;

    typedef struct packed {
        logic                  line_s1;
        logic                  line_s2;
        logic                  aux_s1;
        logic                  aux_s2;
        logic                  mgt_s1;
        logic                  mgt_s2;
        logic                  cs_s1;
        logic                  cs_s2;
        logic                  khi_s1;
        logic                  khi_s2;
        logic                  klo_s1;
        logic                  klo_s2;
        ssw_lvl_t              kick_lvl;
        ssw_mode_t             mode;
        logic [`SSW_CNT_W-1:0] rst_cnt;
        logic [`SSW_CNT_W-1:0] wd_cnt;
        logic                  long_mode;
        logic                  wdo_n;
        logic                  backup;
        logic                  aux_n;
        logic                  cs_out;
        logic                  ev_wdt;
        logic                  ev_low;
        logic [31:0]           prdata;
    } ssw_main_st_t;
endpackage

//--- logic/ssw_tb_if.sv
// Carries the timebase tick and mode from the timebase to the supervisor.
// Both ends run on the same system clock.
interface ssw_tb_if;
    logic tick;
    logic ext_mode;
    logic tb_level;
    modport src (output tick, output ext_mode, output tb_level);
    modport snk (input tick, input ext_mode, input tb_level);
endinterface

//--- logic/ssw_timebase.sv
// Timebase of the supervisor: internal millisecond divider or external clock.
// Assumes the select and timebase pins are asynchronous to i_clk.
`include "ssw_cfg.svh"
module ssw_timebase
    import ssw_pkg::*;
#(
    parameter int P_TICK_CYCLES = `SSW_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Timebase pins
    input  wire logic i_timebase_select,
    input  wire logic i_timebase_in,
    // Tick towards the supervisor
    ssw_tb_if.src     tb
);
    ssw_tb_st_t s_reg;
    ssw_tb_st_t s_next;

    always_comb begin
        s_next        = s_reg;
        s_next.sel_s1 = i_timebase_select;
        s_next.sel_s2 = s_reg.sel_s1;
        s_next.in_s1  = i_timebase_in;
        s_next.in_s2  = s_reg.in_s1;
        s_next.in_s3  = s_reg.in_s2;
        s_next.tick   = 1'b0;
        if (s_reg.sel_s2) begin
            // Internal oscillator times everything.
            if (s_reg.div == `SSW_DIV_W'(P_TICK_CYCLES - 1)) begin
                s_next.div  = '0;
                s_next.tick = 1'b1;
            end else begin
                s_next.div = s_reg.div + `SSW_DIV_W'(1);
            end
        end else begin
            // A driven clock or a capacitor both toggle the pin.
            s_next.div  = '0;
            s_next.tick = s_reg.in_s2 & ~s_reg.in_s3;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '{sel_s1: 1'b1, sel_s2: 1'b1, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign tb.tick     = s_reg.tick;
    assign tb.ext_mode = ~s_reg.sel_s2;
    assign tb.tb_level = s_reg.in_s2;
endmodule // ssw_timebase

//--- logic/ssw_supervisor.sv
// Supply supervisor and watchdog: timed reset, kick watchdog, status pins,
// chip-select gating, backup-supply selection and an APB status port.
// Assumes comparator results arrive as asynchronous digital levels.
//
// Functional notes
// - Reset held while line low, then 50 ms.
// - Watchdog expiry gives one reset pulse.
// - Each kick transition restarts watchdog count.
// - Floating or mid kick disables watchdog.
// - Expired flag low on timeout, high at kick.
// - Expired flag stays high while watchdog disabled.
// - Low line forces expired flag high.
// - Chip select passes only while line good.
// - Supply-low output follows line sense directly.
// - Active-high reset is inverse of active-low.
// - Backup-active output shows backup supply selected.
// - Supply selection by main, backup and line.
// - Aux fail low when aux sense low.
// - Main below backup forces aux fail low.
// - Select high uses internal oscillator; pulled up.
// - External timebase times reset and watchdog.
// - Internal mode: timebase level picks period.
// - Periods 100 ms and 1.6 s; long first.
// - Long period until first kick after reset.
// - Watchdog restarts at end of every reset.
// - External: 1024, 4096 and 512 cycles.
//
// The placing of the registers and register access over APB are this design's own decisions.
`include "ssw_cfg.svh"

module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter int P_TICK_CYCLES = `SSW_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic                  i_clk,
    input  wire logic                  i_rst,
    // Comparator results and supply compare
    input  wire logic                  i_line_sense_in,
    input  wire logic                  i_aux_sense_in,
    input  wire logic                  i_main_above_backup,
    // Three-level kick, decoded: both low means mid or floating
    input  wire logic                  i_kick_high,
    input  wire logic                  i_kick_low,
    // Timebase pins
    input  wire logic                  i_timebase_select,
    input  wire logic                  i_timebase_in,
    // Chip select to gate
    input  wire logic                  i_cs_n,
    // Status and reset outputs
    output logic                       o_reset_n,
    output logic                       o_reset,
    output logic                       o_watchdog_expired_n,
    output logic                       o_supply_low_n,
    output logic                       o_aux_fail_n,
    output logic                       o_backup_active,
    output logic                       o_cs_n,
    // APB slave
    input  wire logic                  i_psel,
    input  wire logic                  i_penable,
    input  wire logic                  i_pwrite,
    input  wire logic [`SSW_ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]           i_pwdata,
    output logic [31:0]                o_prdata,
    output logic                       o_pready,
    output logic                       o_pslverr
);
    ssw_main_st_t          s_reg;
    ssw_main_st_t          s_next;
    ssw_lvl_t              kick_now;
    logic                  kick_ev;
    logic                  wd_expire;
    logic                  rst_done;
    logic                  addr_ok;
    logic [`SSW_CNT_W-1:0] period;
    logic [`SSW_CNT_W-1:0] rst_len;
    logic [31:0]           rd_mux;

    ssw_tb_if tb_link ();

    ssw_timebase #(
        .P_TICK_CYCLES (P_TICK_CYCLES)
    ) u_timebase (
        .i_clk             (i_clk),
        .i_rst             (i_rst),
        .i_timebase_select (i_timebase_select),
        .i_timebase_in     (i_timebase_in),
        .tb                (tb_link.src)
    );

    // Reset length and watchdog period for the active timebase.
    always_comb begin
        if (tb_link.ext_mode) begin
            rst_len = `SSW_EXT_RST;
            period  = s_reg.long_mode ? `SSW_EXT_LONG : `SSW_EXT_SHORT;
        end else begin
            rst_len = `SSW_CNT_W'(`SSW_INT_RST);
            // Timebase pin high keeps the long period.
            if (s_reg.long_mode || tb_link.tb_level) begin
                period = `SSW_CNT_W'(`SSW_INT_LONG);
            end else begin
                period = `SSW_CNT_W'(`SSW_INT_SHORT);
            end
        end
    end

    // Decode of the synchronised three-level kick.
    always_comb begin
        if (s_reg.khi_s2 && !s_reg.klo_s2) begin
            kick_now = SSW_LVL_HIGH;
        end else if (s_reg.klo_s2 && !s_reg.khi_s2) begin
            kick_now = SSW_LVL_LOW;
        end else begin
            kick_now = SSW_LVL_MID;
        end
    end

    // A change through mid is not a kick: mid may just be a floating pin.
    assign kick_ev = (kick_now != SSW_LVL_MID)
                   && (s_reg.kick_lvl != SSW_LVL_MID)
                   && (kick_now != s_reg.kick_lvl);

    assign wd_expire = (s_reg.mode == SSW_SUP_RUN) && s_reg.line_s2
                     && (kick_now != SSW_LVL_MID) && !kick_ev
                     && tb_link.tick
                     && (s_reg.wd_cnt >= period - `SSW_CNT_W'(1));

    // At or past the end, so a period cut short by a pin change still ends.
    assign rst_done = tb_link.tick
                    && (s_reg.rst_cnt >= rst_len - `SSW_CNT_W'(1));

    // Register read data, sampled in the setup phase.
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = '0;
        if (i_paddr == `SSW_REG_STATUS) begin
            rd_mux[`SSW_ST_LINE]   = s_reg.line_s2;
            rd_mux[`SSW_ST_WDO]    = s_reg.wdo_n;
            rd_mux[`SSW_ST_RST]    = (s_reg.mode == SSW_SUP_RESET);
            rd_mux[`SSW_ST_BACKUP] = s_reg.backup;
            rd_mux[`SSW_ST_AUX]    = s_reg.aux_n;
            rd_mux[`SSW_ST_LONG]   = s_reg.long_mode;
            rd_mux[`SSW_ST_EXT]    = tb_link.ext_mode;
        end else if (i_paddr == `SSW_REG_EVENTS) begin
            rd_mux[`SSW_EV_WDT] = s_reg.ev_wdt;
            rd_mux[`SSW_EV_LOW] = s_reg.ev_low;
        end else if (i_paddr == `SSW_REG_WDCNT) begin
            rd_mux[`SSW_CNT_W-1:0] = s_reg.wd_cnt;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_comb begin
        s_next         = s_reg;
        s_next.line_s1 = i_line_sense_in;
        s_next.line_s2 = s_reg.line_s1;
        s_next.aux_s1  = i_aux_sense_in;
        s_next.aux_s2  = s_reg.aux_s1;
        s_next.mgt_s1  = i_main_above_backup;
        s_next.mgt_s2  = s_reg.mgt_s1;
        s_next.cs_s1   = i_cs_n;
        s_next.cs_s2   = s_reg.cs_s1;
        s_next.khi_s1  = i_kick_high;
        s_next.khi_s2  = s_reg.khi_s1;
        s_next.klo_s1  = i_kick_low;
        s_next.klo_s2  = s_reg.klo_s1;
        s_next.kick_lvl = kick_now;

        if (!s_reg.line_s2) begin
            // Low line holds reset and restarts its delay.
            s_next.mode      = SSW_SUP_RESET;
            s_next.rst_cnt   = '0;
            s_next.wd_cnt    = '0;
            s_next.long_mode = 1'b1;
            s_next.wdo_n     = 1'b1;
        end else if (s_reg.mode == SSW_SUP_RESET) begin
            s_next.wd_cnt = '0;
            if (rst_done) begin
                // Watchdog starts fresh, long period first.
                s_next.mode      = SSW_SUP_RUN;
                s_next.rst_cnt   = '0;
                s_next.long_mode = 1'b1;
            end else if (tb_link.tick) begin
                s_next.rst_cnt = s_reg.rst_cnt + `SSW_CNT_W'(1);
            end
        end else if (kick_now == SSW_LVL_MID) begin
            // Disabled watchdog: no count and no expiry.
            s_next.wd_cnt = '0;
            s_next.wdo_n  = 1'b1;
        end else if (kick_ev) begin
            // First kick after reset enables the short period.
            s_next.wd_cnt    = '0;
            s_next.long_mode = 1'b0;
            s_next.wdo_n     = 1'b1;
        end else if (wd_expire) begin
            s_next.wdo_n     = 1'b0;
            s_next.mode      = SSW_SUP_RESET;
            s_next.rst_cnt   = '0;
            s_next.wd_cnt    = '0;
            s_next.long_mode = 1'b1;
        end else if (tb_link.tick) begin
            s_next.wd_cnt = s_reg.wd_cnt + `SSW_CNT_W'(1);
        end

        // Selection holds in the mixed cases, which gives hysteresis.
        if (s_reg.mgt_s2 && s_reg.line_s2) begin
            s_next.backup = 1'b0;
        end else if (!s_reg.mgt_s2 && !s_reg.line_s2) begin
            s_next.backup = 1'b1;
        end
        s_next.aux_n  = s_reg.aux_s2 & s_reg.mgt_s2;
        s_next.cs_out = s_reg.cs_s2 | ~s_reg.line_s2;

        // Sticky events: a new event wins over a clear in the same cycle.
        if (i_psel && i_penable && i_pwrite
                && (i_paddr == `SSW_REG_EVENTS)) begin
            s_next.ev_wdt = s_reg.ev_wdt & ~i_pwdata[`SSW_EV_WDT];
            s_next.ev_low = s_reg.ev_low & ~i_pwdata[`SSW_EV_LOW];
        end
        if (wd_expire) begin
            s_next.ev_wdt = 1'b1;
        end
        if (!s_reg.line_s2) begin
            s_next.ev_low = 1'b1;
        end

        if (i_psel && !i_penable) begin
            s_next.prdata = i_pwrite ? 32'h00000000 : rd_mux;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_reg <= '{mode: SSW_SUP_RESET, kick_lvl: SSW_LVL_MID,
                       long_mode: 1'b1, wdo_n: 1'b1, aux_n: 1'b0,
                       cs_out: 1'b1, cs_s1: 1'b1, cs_s2: 1'b1,
                       default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // Reset pins come from one flip-flop so they never disagree.
    assign o_reset_n            = (s_reg.mode == SSW_SUP_RUN);
    assign o_reset              = ~o_reset_n;
    assign o_watchdog_expired_n = s_reg.wdo_n;
    // Only the input synchroniser delays this pin.
    assign o_supply_low_n       = s_reg.line_s2;
    assign o_aux_fail_n         = s_reg.aux_n;
    assign o_backup_active      = s_reg.backup;
    assign o_cs_n               = s_reg.cs_out;
    assign o_prdata             = s_reg.prdata;
    assign o_pready             = 1'b1;
    assign o_pslverr            = i_psel & i_penable & ~addr_ok;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    AST_RST_INV: assert property (o_reset == !o_reset_n)
        else $error("Active-high reset is not the inverse.");

    AST_LOW_RST: assert property (
        !s_reg.line_s2 |=> !o_reset_n [*2])
        else $error("Reset released while line is low.");

    AST_RST_HOLD: assert property (
        (!o_reset_n && s_reg.line_s2 && !rst_done) |=> !o_reset_n)
        else $error("Reset released before its delay ran out.");

    AST_EXP_RST: assert property (
        wd_expire |=> (!o_reset_n && !o_watchdog_expired_n))
        else $error("Expiry did not start a reset pulse.");

    AST_REL_DONE: assert property (
        $rose(o_reset_n) |-> $past(rst_done))
        else $error("Reset released without a finished delay.");

    AST_EV_WDT: assert property (
        wd_expire |=> s_reg.ev_wdt)
        else $error("Expiry event not recorded.");

    AST_KICK_RST: assert property (
        (kick_ev && s_reg.line_s2 && o_reset_n)
        |=> (s_reg.wd_cnt == '0) && o_watchdog_expired_n
            && !s_reg.long_mode)
        else $error("Kick did not restart the watchdog.");

    AST_MID_OFF: assert property (
        (kick_now == SSW_LVL_MID && s_reg.line_s2 && o_reset_n)
        |=> (s_reg.wd_cnt == '0) && o_reset_n)
        else $error("Watchdog counted or expired while disabled.");

    AST_WDO_MID: assert property (
        (kick_now == SSW_LVL_MID && s_reg.line_s2 && o_reset_n)
        |=> o_watchdog_expired_n)
        else $error("Expired flag low while watchdog disabled.");

    AST_WDO_LOW: assert property (
        !o_supply_low_n |=> o_watchdog_expired_n)
        else $error("Expired flag not forced high on low line.");

    AST_CS_GATE: assert property (
        !s_reg.line_s2 |=> o_cs_n)
        else $error("Chip select passed during low line.");

    AST_CS_PASS: assert property (
        (s_reg.line_s2 && !s_reg.cs_s2) |=> !o_cs_n)
        else $error("Chip select blocked while line is good.");

    AST_EV_LOW: assert property (
        !s_reg.line_s2 |=> s_reg.ev_low)
        else $error("Low line event not recorded.");

    AST_AUX_HIGH: assert property (
        (s_reg.aux_s2 && s_reg.mgt_s2) |=> o_aux_fail_n)
        else $error("Aux fail output low with good sense.");

    AST_AUX_LOW: assert property (
        (!s_reg.aux_s2 || !s_reg.mgt_s2) |=> !o_aux_fail_n)
        else $error("Aux fail output not low.");

    AST_SUPPLY: assert property (
        (s_reg.mgt_s2 && s_reg.line_s2) |=> !o_backup_active)
        else $error("Backup kept while main supply is good.");

    AST_BACKUP_ON: assert property (
        (!s_reg.mgt_s2 && !s_reg.line_s2) |=> o_backup_active)
        else $error("Backup not selected on supply loss.");

    AST_TICK_ONLY: assert property (
        (o_reset_n && s_reg.line_s2 && !tb_link.tick && !kick_ev
         && (kick_now != SSW_LVL_MID)) |=> $stable(s_reg.wd_cnt))
        else $error("Watchdog counted without a timebase tick.");

    AST_LONG_AFTER: assert property (
        $rose(o_reset_n) |-> s_reg.long_mode && (s_reg.wd_cnt == '0))
        else $error("Watchdog not restarted long after reset.");

    COV_EXPIRE: cover property (wd_expire);
    COV_KICK:   cover property (kick_ev ##1 !s_reg.long_mode);
    COV_LOWREL: cover property (!s_reg.line_s2 ##1 s_reg.line_s2
                                ##1 !o_reset_n);
    COV_BACKUP: cover property ($rose(o_backup_active));
endmodule // ssw_supervisor

//--- verification/ssw_host_model.sv
// Host processor model that services the watchdog kick pin.
// Assumes the bench picks the mode: 0 floating, 1 toggling, 2 held.
module ssw_host_model #(
    parameter int P_GAP = 1000
) (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Mode chosen by the bench
    input  wire logic [1:0] i_mode,
    // Decoded kick pin and a pulse after each flip
    output logic            o_kick_high,
    output logic            o_kick_low,
    output logic            o_flip
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt;
    logic lvl;

    // Flipping well inside the short period keeps the watchdog quiet.
    always @(posedge i_clk or posedge i_rst) begin
        o_flip <= 1'b0;
        if (i_rst) begin
            cnt <= 0;
            lvl <= 1'b0;
        end else if (i_mode == 2'h1) begin
            cnt <= (cnt >= P_GAP - 1) ? 0 : cnt + 1;
            if (cnt >= P_GAP - 1) begin
                lvl    <= ~lvl;
                o_flip <= 1'b1;
            end
        end
    end

    // A floating pin decodes as neither level.
    assign o_kick_high = (i_mode != 2'h0) & lvl;
    assign o_kick_low  = (i_mode != 2'h0) & ~lvl;
endmodule // ssw_host_model

//--- verification/tb_supply_supervisor_watchdog.sv
// Self-checking bench for the supply supervisor and watchdog.
// Assumes a shortened tick of 20 clocks so every period fits in the run.
`include "ssw_cfg.svh"
module tb_supply_supervisor_watchdog;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20;
    logic i_clk = 0, i_rst = 1, line = 1, aux = 1, mab = 1, tsel = 1;
    logic tlev = 1, ext = 0, tin = 1, cs_n = 1, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [1:0]  kmode = 0;
    logic [2:0]  div = 0;
    logic rst_n, rst, wdo_n, low_n, aux_n, bkp, cs_o, prdy, perr, err;
    logic khi, klo, flip;
    int failures = 0, checks_done = 0, n;

    always #25 i_clk = ~i_clk;
    // External clock of eight system clocks, else the period select level.
    always @(posedge i_clk) begin
        div <= div + 3'h1;
        tin <= ext ? div[2] : tlev;
    end

    ssw_supervisor #(.P_TICK_CYCLES(T)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_line_sense_in(line),
        .i_aux_sense_in(aux), .i_main_above_backup(mab),
        .i_kick_high(khi), .i_kick_low(klo), .i_timebase_select(tsel),
        .i_timebase_in(tin), .i_cs_n(cs_n), .o_reset_n(rst_n),
        .o_reset(rst), .o_watchdog_expired_n(wdo_n),
        .o_supply_low_n(low_n), .o_aux_fail_n(aux_n),
        .o_backup_active(bkp), .o_cs_n(cs_o), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(prdy),
        .o_pslverr(perr));
    ssw_host_model host (.i_clk(i_clk), .i_rst(i_rst), .i_mode(kmode),
        .o_kick_high(khi), .o_kick_low(klo), .o_flip(flip));

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test;
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
        end while (prdy !== 1'b1);
        rd  = prdata;
        err = perr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask

    // Counts clocks until reset (0) or the expired flag (1) reaches v.
    task automatic till(input int w, input logic v, input int lim);
        n = 0;
        while (((w == 0) ? rst_n : wdo_n) !== v && n < lim) begin
            @(posedge i_clk);
            n++;
        end
    endtask

    task automatic span(input string nm, input int lo, input int hi);
        check(nm, {31'h0, (n >= lo && n <= hi)}, 32'h1);
    endtask

    task automatic quiet(input int c);
        int lows;
        lows = 0;
        repeat (c) begin
            @(posedge i_clk);
            if (rst_n !== 1'b1) lows++;
        end
        check("no_reset", lows, 0);
    endtask

    // One transition of the kick pin, then the level is held.
    task automatic one_kick;
        int k;
        k = 0;
        @(posedge i_clk);
        kmode <= 2'h1;
        do begin
            @(posedge i_clk);
            k++;
        end while (flip !== 1'b1 && k < 3000);
        check("kick_seen", flip, 32'h1);
        kmode <= 2'h2;
    endtask

    always @(negedge i_clk) begin
        if (!i_rst) check("reset_pair", rst, {31'h0, ~rst_n});
    end

    initial begin
        #3000000;
        failures++;
        finish_test;
    end

    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        till(0, 1'b1, 3000);
        span("boot_delay", 49 * T, 51 * T + 6);
        tlev  <= 1'b0;
        kmode <= 2'h1;
        quiet(6000);
        one_kick();
        till(1, 1'b0, 4000);
        span("short_expiry", 99 * T, 101 * T);
        repeat (2) @(posedge i_clk);
        check("expiry_reset", rst_n, 32'h0);
        till(0, 1'b1, 4000);
        span("pulse_len", 48 * T, 51 * T);
        check("wdo_held", wdo_n, 32'h0);
        quiet(150 * T);
        apb(1'b0, `SSW_REG_STATUS, 32'h0);
        check("status_long", rd & 32'h20, 32'h20);
        check("pready", prdy, 32'h1);
        one_kick();
        repeat (4) @(posedge i_clk);
        check("wdo_kick", wdo_n, 32'h1);
        till(1, 1'b0, 4000);
        span("short_again", 99 * T - 8, 101 * T);
        line <= 1'b0;
        mab  <= 1'b0;
        cs_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        check("wdo_line", wdo_n, 32'h1);
        check("low_out", low_n, 32'h0);
        check("cs_gate", cs_o, 32'h1);
        check("line_reset", rst_n, 32'h0);
        check("backup_on", bkp, 32'h1);
        check("aux_main", aux_n, 32'h0);
        apb(1'b1, `SSW_REG_EVENTS, 32'h3);
        apb(1'b0, `SSW_REG_EVENTS, 32'h0);
        check("events_clear", rd, 32'h2);
        @(posedge i_clk);
        line <= 1'b1;
        mab  <= 1'b1;
        repeat (3) @(posedge i_clk);
        check("low_back", low_n, 32'h1);
        @(posedge i_clk);
        check("cs_pass", cs_o, 32'h0);
        check("backup_off", bkp, 32'h0);
        till(0, 1'b1, 4000);
        n = n + 4;
        span("line_delay", 49 * T, 51 * T + 6);
        one_kick();
        @(posedge i_clk);
        kmode <= 2'h0;
        quiet(150 * T);
        check("wdo_off", wdo_n, 32'h1);
        aux <= 1'b0;
        repeat (4) @(posedge i_clk);
        check("aux_low", aux_n, 32'h0);
        aux <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("aux_high", aux_n, 32'h1);
        line <= 1'b0;
        tsel <= 1'b0;
        ext  <= 1'b1;
        repeat (8) @(posedge i_clk);
        line <= 1'b1;
        till(0, 1'b1, 6000);
        span("ext_reset", 511 * 8, 513 * 8 + 8);
        apb(1'b0, `SSW_REG_STATUS, 32'h0);
        check("status_ext", rd & 32'h40, 32'h40);
        apb(1'b0, 12'h00C, 32'h0);
        check("unmapped_err", err, 32'h1);
        check("unmapped_data", rd, 32'h0);
        finish_test;
    end
endmodule // tb_supply_supervisor_watchdog
